// ===== dodt_sync_odt.sv
// Synchronous on-die termination control with latency, dynamic write termination and checks
// Overview of operation
// - Sync mode needs DLL locked and termination enabled
// - Sync applies CKE high, active PD, DLL-on PD
// - Termination follows sampled ODT after fixed latency
// - Latency equals write latency minus two
// - Additive latency also delays internal ODT
// - Write termination starts latency after write
// - Nominal returns four or six plus latency
// - Dynamic mode when either write code bit set
// - Nominal strength from three-bit code, zero off
`timescale 1ns/1ps
module dodt_sync_odt import dodt_pkg::*; #(
    parameter int LAT_W = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Pins from the controller
    input wire logic odt_pin,
    input wire logic cke_pin,
    // Decoded write command, same clock
    input wire logic wr_cmd,
    input wire logic wr_bl8,
    // Device state, same clock
    input wire logic dll_locked,
    input wire logic bank_open,
    // Mode register fields
    input wire logic mr0_dll_pd,
    input wire logic [3:0] mr0_cas_lat,
    input wire logic [1:0] mr1_add_lat,
    input wire logic [2:0] mr1_rtt_nom,
    input wire logic [1:0] mr2_rtt_wr,
    input wire logic [3:0] mr2_cas_wr_lat,
    // Monitor control
    input wire logic err_clr,
    // Termination outputs
    output logic rtt_on_q,
    output logic rtt_wr_sel_q,
    output logic [2:0] rtt_nom_code_q,
    output logic [1:0] rtt_wr_code_q,
    // Mode and monitor status
    output logic sync_mode_q,
    output logic async_mode_q,
    output logic odth_err_q
);
    generate
        if (LAT_W < 5 || LAT_W > 8) begin : g_bad
            $error("dodt_sync_odt: LAT_W must lie in 5..8");
        end
    endgenerate

    // Turn-on and turn-off share one latency: CWL + AL - 2
    function automatic logic [LAT_W-1:0] term_lat(input logic [3:0] cwl, input logic [3:0] cl,
                                                  input logic [1:0] al_code);
        logic [5:0] al;
        logic [5:0] sum;
        al = 6'h00;
        sum = 6'h00;
        case (dodt_al_type'(al_code))
            AL_CL_M1: al = {2'h0, cl} - 6'h01;
            AL_CL_M2: al = {2'h0, cl} - 6'h02;
            default: al = 6'h00;
        endcase
        sum = {2'h0, cwl} + al - LAT_OFFSET;
        return LAT_W'(sum);
    endfunction

    logic odt_m_q, odt_s_q, cke_m_q, cke_s_q;
    logic odt_prev_q;
    logic [1:0] wr_dly_q;
    logic [LAT_W-1:0] lat;
    logic [LAT_W-1:0] odt_sel, wr_sel;
    logic odt_tap;
    logic [1:0] wr_tap;
    logic term_en, dyn_en, sync_now;
    logic odt_rise, odt_fall, wr_aligned;
    logic rtt_on_d, rtt_wr_sel_d, sync_mode_d, async_mode_d;
    logic [2:0] cnt_q, cnt_d;
    logic [2:0] hold_q, hold_d;
    logic odth_err_d;
    logic wr_bl8_dly_q;
    logic [1:0] bl8_dly_q;

    // Pins are asynchronous to core_clk; first stage feeds only the second
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            odt_m_q <= 1'b0;
            odt_s_q <= 1'b0;
            cke_m_q <= 1'b0;
            cke_s_q <= 1'b0;
        end else begin
            odt_m_q <= odt_pin;
            odt_s_q <= odt_m_q;
            cke_m_q <= cke_pin;
            cke_s_q <= cke_m_q;
        end
    end

    always_comb begin
        lat = term_lat(mr2_cas_wr_lat, mr0_cas_lat, mr1_add_lat);
        // Latency below the pin skew cannot be met; clamp to the shortest path
        odt_sel = (lat >= LAT_W'(ODT_PIPE_SKEW)) ? lat - LAT_W'(ODT_PIPE_SKEW) : '0;
        wr_sel = (lat >= LAT_W'(WR_PIPE_SKEW)) ? lat - LAT_W'(WR_PIPE_SKEW) : '0;
        dyn_en = |mr2_rtt_wr;
        term_en = (mr1_rtt_nom != RTT_NOM_OFF) || dyn_en;
        sync_now = dll_locked && term_en && (cke_s_q || bank_open || mr0_dll_pd);
    end

    dodt_delay_line #(
        .WIDTH(1),
        .SEL_W(LAT_W)
    ) u_odt_line (
        .core_clk(core_clk),
        .nrst(nrst),
        .din(odt_s_q),
        .sel(odt_sel),
        .dout(odt_tap)
    );

    dodt_delay_line #(
        .WIDTH(2),
        .SEL_W(LAT_W)
    ) u_wr_line (
        .core_clk(core_clk),
        .nrst(nrst),
        .din({wr_cmd, wr_bl8}),
        .sel(wr_sel),
        .dout(wr_tap)
    );

    // Termination state and write termination window
    always_comb begin
        rtt_on_d = sync_now && odt_tap;
        sync_mode_d = sync_now;
        async_mode_d = term_en && !sync_now;
        cnt_d = cnt_q;
        if (wr_tap[1]) begin
            cnt_d = (wr_tap[0] ? CWN8_LEN : CWN4_LEN) - 3'h1;
        end else if (cnt_q != 3'h0) begin
            cnt_d = cnt_q - 3'h1;
        end
        rtt_wr_sel_d = dyn_en && (wr_tap[1] || (cnt_q != 3'h0));
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rtt_on_q <= 1'b0;
            rtt_wr_sel_q <= 1'b0;
            rtt_nom_code_q <= RTT_NOM_OFF;
            rtt_wr_code_q <= RTT_WR_OFF;
            sync_mode_q <= 1'b0;
            async_mode_q <= 1'b0;
            cnt_q <= 3'h0;
        end else begin
            rtt_on_q <= rtt_on_d;
            rtt_wr_sel_q <= rtt_wr_sel_d;
            rtt_nom_code_q <= mr1_rtt_nom;
            rtt_wr_code_q <= mr2_rtt_wr;
            sync_mode_q <= sync_mode_d;
            async_mode_q <= async_mode_d;
            cnt_q <= cnt_d;
        end
    end

    // Minimum high monitor; write is delayed to line up with the synchronised pin
    always_comb begin
        odt_rise = odt_s_q && !odt_prev_q;
        odt_fall = !odt_s_q && odt_prev_q;
        wr_aligned = wr_dly_q[1];
        hold_d = (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
        if (odt_rise && (hold_d < ODTH4_CYC - 3'h1)) begin
            hold_d = ODTH4_CYC - 3'h1;
        end
        if (wr_aligned && odt_s_q) begin
            if (wr_bl8_dly_q && (hold_d < ODTH8_CYC - 3'h1)) begin
                hold_d = ODTH8_CYC - 3'h1;
            end else if (hold_d < ODTH4_CYC - 3'h1) begin
                hold_d = ODTH4_CYC - 3'h1;
            end
        end
        // A new violation wins over a clear in the same cycle
        odth_err_d = (odth_err_q && !err_clr) || (odt_fall && (hold_q != 3'h0));
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            odt_prev_q <= 1'b0;
            wr_dly_q <= 2'h0;
            bl8_dly_q <= 2'h0;
            hold_q <= 3'h0;
            odth_err_q <= 1'b0;
        end else begin
            odt_prev_q <= odt_s_q;
            wr_dly_q <= {wr_dly_q[0], wr_cmd};
            bl8_dly_q <= {bl8_dly_q[0], wr_bl8};
            hold_q <= hold_d;
            odth_err_q <= odth_err_d;
        end
    end
    assign wr_bl8_dly_q = bl8_dly_q[1];

    // Helper ages for the checks below
    logic [AGE_W-1:0] on_age_q, off_age_q, wr_age_q;
    logic last_bl8_q;
    logic [AGE_W-1:0] lat_m1, lat_a, lat_cwn4, lat_cwn8;
    function automatic logic [AGE_W-1:0] age_next(input logic start, input logic [AGE_W-1:0] a);
        if (start) begin
            return AGE_W'(1);
        end
        return (&a) ? a : a + AGE_W'(1);
    endfunction
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            on_age_q <= '1;
            off_age_q <= '1;
            wr_age_q <= '1;
            last_bl8_q <= 1'b0;
        end else begin
            on_age_q <= age_next(odt_rise, on_age_q);
            off_age_q <= age_next(odt_fall, off_age_q);
            wr_age_q <= age_next(wr_cmd, wr_age_q);
            last_bl8_q <= wr_cmd ? wr_bl8 : last_bl8_q;
        end
    end
    assign lat_a = AGE_W'(lat);
    assign lat_m1 = lat_a - AGE_W'(1);
    assign lat_cwn4 = lat_a + AGE_W'(CWN4_LEN);
    assign lat_cwn8 = lat_a + AGE_W'(CWN8_LEN);

    sequence s_wr_window;
        rtt_wr_sel_q [*4];
    endsequence

    a_rtt_on_lat: assert property (@(posedge core_clk) disable iff (!nrst)
        (on_age_q == lat_m1 && sync_mode_q && lat >= LAT_W'(ODT_PIPE_SKEW)) |-> rtt_on_q)
        else $error("termination not on at turn-on latency");
    a_rtt_off_lat: assert property (@(posedge core_clk) disable iff (!nrst)
        (off_age_q == lat_m1 && lat >= LAT_W'(ODT_PIPE_SKEW)) |-> !rtt_on_q)
        else $error("termination not off at turn-off latency");
    a_no_term_idle: assert property (@(posedge core_clk) disable iff (!nrst)
        !term_en |=> !rtt_on_q && !rtt_wr_sel_q)
        else $error("termination shown with none enabled");
    a_wr_switch_lat: assert property (@(posedge core_clk) disable iff (!nrst)
        (wr_age_q == lat_a && $past(dyn_en) && dyn_en) |=> rtt_wr_sel_q)
        else $error("write termination missing at write latency");
    a_wr_back_nom: assert property (@(posedge core_clk) disable iff (!nrst)
        (last_bl8_q ? wr_age_q == lat_cwn8 : wr_age_q == lat_cwn4) |=> !rtt_wr_sel_q)
        else $error("write termination not returned to nominal");
    // Dropping dynamic mode may cut a window short, so it aborts the check
    a_wr_min_len: assert property (@(posedge core_clk) disable iff (!nrst || !dyn_en)
        (wr_tap[1] && dyn_en) |=> s_wr_window)
        else $error("write termination window too short");
    a_dyn_disabled: assert property (@(posedge core_clk) disable iff (!nrst)
        !dyn_en |=> !rtt_wr_sel_q)
        else $error("write termination with dynamic mode off");
    a_async_handoff: assert property (@(posedge core_clk) disable iff (!nrst)
        async_mode_q |-> !rtt_on_q && !sync_mode_q)
        else $error("latency termination outside sync mode");
    a_sync_entry: assert property (@(posedge core_clk) disable iff (!nrst)
        (dll_locked && term_en && !cke_s_q && bank_open) |=> sync_mode_q)
        else $error("active power-down left sync mode");
    a_odth_flag: assert property (@(posedge core_clk) disable iff (!nrst)
        (odt_fall && hold_q != 3'h0) |=> odth_err_q)
        else $error("minimum high violation not flagged");

endmodule

// ===== dodt_pkg.sv
// Shared constants and types for the synchronous termination control block
package dodt_pkg;

    // Termination latency is write latency minus this many cycles
    localparam logic [5:0] LAT_OFFSET = 6'h02;
    // Pin path skew: two synchroniser stages plus the output flop
    localparam logic [4:0] ODT_PIPE_SKEW = 5'h03;
    // Command path skew: only the output flop
    localparam logic [4:0] WR_PIPE_SKEW = 5'h01;

    // Minimum high windows, in clock cycles
    localparam logic [2:0] ODTH4_CYC = 3'h4;
    localparam logic [2:0] ODTH8_CYC = 3'h6;

    // Length of write termination after a write, in clock cycles
    localparam logic [2:0] CWN4_LEN = 3'h4;
    localparam logic [2:0] CWN8_LEN = 3'h6;

    // Reset values
    localparam logic [2:0] RTT_NOM_OFF = 3'h0;
    localparam logic [1:0] RTT_WR_OFF = 2'h0;

    // Saturating age counters used by the checks
    localparam int AGE_W = 6;

    // Additive latency selection
    typedef enum logic [1:0] {
        AL_ZERO = 2'h0,
        AL_CL_M1 = 2'h1,
        AL_CL_M2 = 2'h2,
        AL_RSVD = 2'h3
    } dodt_al_type;

endpackage

// ===== dodt_delay_line.sv
// Tapped shift register used to delay the termination request and write events
`timescale 1ns/1ps
module dodt_delay_line #(
    parameter int WIDTH = 1,
    parameter int SEL_W = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Data in and selected tap out
    input wire logic [WIDTH-1:0] din,
    input wire logic [SEL_W-1:0] sel,
    output logic [WIDTH-1:0] dout
);
    localparam int DEPTH = 1 << SEL_W;

    logic [WIDTH-1:0] stage_q [DEPTH];
    logic [WIDTH-1:0] stage_d [DEPTH];

    generate
        if (WIDTH < 1 || SEL_W < 1 || SEL_W > 8) begin : g_bad
            $error("dodt_delay_line: unsupported WIDTH or SEL_W");
        end
    endgenerate

    always_comb begin
        stage_d[0] = din;
        for (int i = 1; i < DEPTH; i++) begin
            stage_d[i] = stage_q[i-1];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_q[i] <= stage_d[i];
            end
        end
    end

    // Tap zero is one cycle after din; every tap is reachable since DEPTH fills sel
    assign dout = stage_q[sel];

endmodule

// ===== dodt_ctrl_model.sv
// Behavioural memory controller driving the termination pin and write commands
`timescale 1ns/1ps
module dodt_ctrl_model (
    // Clock
    input wire logic core_clk,
    // Pin and decoded commands toward the device
    output logic odt_pin,
    output logic wr_cmd,
    output logic wr_bl8
);
    initial begin
        odt_pin = 1'b0;
        wr_cmd = 1'b0;
        wr_bl8 = 1'b0;
    end

    // One high period with writes at offsets w1, w2 (-1 for none); cut > 0 forces a short hold
    task automatic burst(input int w1, input int w2, input logic bl8, input int cut);
        int hold;
        hold = ((w2 > w1) ? w2 : w1) + (bl8 ? 6 : 4);
        if (hold < 4) hold = 4;
        if (cut > 0) hold = cut;
        // Burst type stays put until the next period, so a late look still sees it
        wr_bl8 = bl8;
        // Pin may stay up across writes when only write termination is on
        for (int i = 0; i < hold; i++) begin
            odt_pin = 1'b1;
            wr_cmd = (i == w1 || i == w2);
            @(negedge core_clk);
        end
        odt_pin = 1'b0;
        wr_cmd = 1'b0;
        // Low gap wide enough to fit a read burst before termination returns
        repeat (6) @(negedge core_clk);
    endtask
endmodule

// ===== dodt_sync_odt_tb_top.sv
// Self-checking testbench for the synchronous termination control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module dodt_sync_odt_tb_top;
    import dodt_pkg::*;
    logic core_clk, nrst, odt_pin, cke_pin, wr_cmd, wr_bl8, dll_locked, bank_open;
    logic mr0_dll_pd, err_clr, rtt_on_q, rtt_wr_sel_q, sync_mode_q, async_mode_q, odth_err_q;
    logic [3:0] mr0_cas_lat, mr2_cas_wr_lat;
    logic [2:0] mr1_rtt_nom, rtt_nom_code_q;
    logic [1:0] mr1_add_lat, mr2_rtt_wr, rtt_wr_code_q;
    logic [31:0] ph, wh, bh;
    logic chk_en, e;
    int errors, n_checks, l;

    dodt_ctrl_model u_ctrl (.core_clk, .odt_pin, .wr_cmd, .wr_bl8);
    dodt_sync_odt #(.LAT_W(5)) u_dut (.core_clk, .nrst, .odt_pin, .cke_pin, .wr_cmd, .wr_bl8,
        .dll_locked, .bank_open, .mr0_dll_pd, .mr0_cas_lat, .mr1_add_lat, .mr1_rtt_nom,
        .mr2_rtt_wr, .mr2_cas_wr_lat, .err_clr, .rtt_on_q, .rtt_wr_sel_q, .rtt_nom_code_q,
        .rtt_wr_code_q, .sync_mode_q, .async_mode_q, .odth_err_q);

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic ten();
        return (mr1_rtt_nom != 3'h0) || (mr2_rtt_wr != 2'h0);
    endfunction
    function automatic logic sync_exp();
        return dll_locked && ten() && (cke_pin || bank_open || mr0_dll_pd);
    endfunction
    // Turn-on and turn-off latency; additive code 3 counts as zero
    function automatic int lat();
        int al;
        al = (mr1_add_lat == 2'h1) ? mr0_cas_lat - 1 : (mr1_add_lat == 2'h2) ? mr0_cas_lat - 2 : 0;
        lat = mr2_cas_wr_lat + al - 2;
        if (lat < 3) lat = 3;
    endfunction

    // Pin and command history, index 0 is the newest sample
    always @(posedge core_clk) begin
        if (!nrst) begin
            ph <= 32'h0;
            wh <= 32'h0;
            bh <= 32'h0;
        end else begin
            ph <= {ph[30:0], odt_pin};
            wh <= {wh[30:0], wr_cmd};
            bh <= {bh[30:0], wr_bl8};
        end
    end

    always @(negedge core_clk) begin
        if (chk_en) begin
            l = lat();
            `CHK("rtt_on_q", ph[l] & sync_exp(), rtt_on_q)
            e = 1'b0;
            // Oldest first, so the newest write decides the window
            for (int j = 8; j >= 0; j--) begin
                if (wh[l + j]) e = (j < (bh[l + j] ? 6 : 4));
            end
            if (sync_exp()) begin
                `CHK("rtt_wr_sel_q", e & (mr2_rtt_wr != 2'h0), rtt_wr_sel_q)
            end
        end
    end

    task automatic set_cfg(input logic [3:0] st, input logic [2:0] nm, input logic [1:0] wr,
                           input logic [3:0] cwl, input logic [1:0] al);
        chk_en = 1'b0;
        {dll_locked, cke_pin, bank_open, mr0_dll_pd} = st;
        mr1_rtt_nom = nm;
        mr2_rtt_wr = wr;
        mr2_cas_wr_lat = cwl;
        mr1_add_lat = al;
        // Long enough for the synchronisers and the deepest delay tap these latencies select to flush
        repeat (20) @(negedge core_clk);
        `CHK("sync_mode_q", sync_exp(), sync_mode_q)
        `CHK("async_mode_q", ten() & !sync_exp(), async_mode_q)
        chk_en = 1'b1;
    endtask

    task automatic run(input int w1, input int w2, input logic bl8, input int cut, input logic bad);
        u_ctrl.burst(w1, w2, bl8, cut);
        `CHK("odth_err_q", bad, odth_err_q)
        err_clr = 1'b1;
        @(negedge core_clk);
        err_clr = 1'b0;
        `CHK("odth_err_q cleared", 1'b0, odth_err_q)
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        errors++;
        stop_test();
    end

    initial begin
        {nrst, cke_pin, dll_locked, bank_open, mr0_dll_pd, err_clr, chk_en} = 7'h0;
        mr0_cas_lat = 4'h6;
        mr1_add_lat = 2'h0;
        mr1_rtt_nom = 3'h0;
        mr2_rtt_wr = 2'h0;
        mr2_cas_wr_lat = 4'h5;
        errors = 0;
        n_checks = 0;
        repeat (6) @(negedge core_clk);
        `CHK("outputs in reset", 10'h000, {rtt_on_q, rtt_wr_sel_q, rtt_nom_code_q,
            rtt_wr_code_q, sync_mode_q, async_mode_q, odth_err_q})
        nrst = 1'b1;
        @(negedge core_clk);
        for (int i = 0; i < 8; i++) begin
            mr1_rtt_nom = i[2:0];
            mr2_rtt_wr = i[1:0];
            @(negedge core_clk);
            `CHK("rtt_nom_code_q", i[2:0], rtt_nom_code_q)
            `CHK("rtt_wr_code_q", i[1:0], rtt_wr_code_q)
        end
        // Latencies 3, 8, 8 and 4 across the additive codes
        for (int i = 0; i < 4; i++) begin
            set_cfg(4'hC, 3'h1, 2'h1, 4'h5 + {3'h0, i[1]}, i[1:0]);
            run(0, -1, 1'b1, 0, 1'b0);
            run(1, -1, 1'b0, 0, 1'b0);
            run(-1, -1, 1'b0, 0, 1'b0);
            run(0, 4, 1'b1, 0, 1'b0);
        end
        run(-1, -1, 1'b0, 3, 1'b1);
        run(0, -1, 1'b1, 5, 1'b1);
        run(1, -1, 1'b0, 4, 1'b1);
        set_cfg(4'hC, 3'h2, 2'h0, 4'h5, 2'h0);
        run(0, -1, 1'b1, 0, 1'b0);
        set_cfg(4'hC, 3'h0, 2'h2, 4'h5, 2'h0);
        run(0, 4, 1'b1, 0, 1'b0);
        set_cfg(4'hC, 3'h0, 2'h0, 4'h5, 2'h0);
        run(0, -1, 1'b0, 0, 1'b0);
        // DLL off, precharge power-down both ways, active power-down
        for (int i = 0; i < 4; i++) begin
            set_cfg(i == 0 ? 4'h7 : (i == 1 ? 4'h8 : (i == 2 ? 4'h9 : 4'hA)), 3'h1, 2'h1,
                    4'h5, 2'h0);
            run(0, -1, 1'b0, 0, 1'b0);
        end
        stop_test();
    end
endmodule
